// ---- rtl/smsp_port.sv ----
// Purpose: serial slave front end and protection status register
// Assumes: pins sampled by 125 MHz clock, sck well below clock/4
// Notes:   array datapath outside; this block grants array writes
module smsp_port (
	// clock and reset
	input  wire logic        clock,
	input  wire logic        nrst,
	input  wire logic        clk_en,
	// serial pins
	input  wire logic        cs_n,
	input  wire logic        sck,
	input  wire logic        si,
	input  wire logic        pause_n,
	input  wire logic        write_guard_n,
	output logic             so,
	output logic             so_oe,
	// array side
	input  wire logic [7:0]  array_rd_data,
	input  wire logic [17:0] array_addr,
	output logic             array_wr_allow,
	output logic             asleep,
	// status view
	output logic [7:0]       status
);
	logic asleep_q;
	logic cs_s;
	logic sck_s;
	logic si_s;
	logic pause_s;
	logic wg_s;
	logic active;
	logic rise;
	logic fall;

	smsp_sync #(.W(5), .RST(5'b11011)) u_sync (
		.clock (clock),
		.nrst  (nrst),
		.en    (clk_en),
		.din   ({cs_n, sck, si, pause_n, write_guard_n}),
		.dout  ({cs_s, sck_s, si_s, pause_s, wg_s})
	);

	assign active = ~cs_s & pause_s & ~asleep_q;

	smsp_edge u_edge (
		.clock  (clock),
		.nrst   (nrst),
		.en     (clk_en),
		.sck    (sck_s),
		.active (active),
		.rise   (rise),
		.fall   (fall)
	);

	smsp_pkg::smsp_state_t state_q, state_d;
	logic [2:0] bit_q, bit_d;
	logic [7:0] shin_q, shin_d;
	logic [7:0] shout_q, shout_d;
	logic       so_q, so_d;
	logic       drive_q, drive_d;
	logic [7:0] nv_q, nv_d;
	logic       permit_q, permit_d;
	logic       asleep_d;
	logic       sleep_arm_q, sleep_arm_d;
	logic       cs_prev_q, cs_prev_d;
	logic [7:0] byte_in;
	logic       byte_done;
	logic       stat_ok;
	logic [7:0] stat_view;

	// bit 0 is tied low, bit 1 is the latch
	assign stat_view = {nv_q[7:2], permit_q, 1'b0};
	assign byte_in   = {shin_q[6:0], si_s};
	assign byte_done = rise & (bit_q == 3'd7);
	assign stat_ok   = permit_q & ~(nv_q[smsp_pkg::STAT_GUARD_EN] & ~wg_s);

	always_comb begin
		state_d     = state_q;
		bit_d       = bit_q;
		shin_d      = shin_q;
		shout_d     = shout_q;
		so_d        = so_q;
		drive_d     = drive_q;
		nv_d        = nv_q;
		permit_d    = permit_q;
		asleep_d    = asleep_q;
		sleep_arm_d = sleep_arm_q;
		cs_prev_d   = cs_s;
		if (cs_s) begin
			// deselect or abort; pause does not reach this branch
			state_d     = smsp_pkg::SMSP_OPCODE;
			bit_d       = smsp_pkg::BIT_CNT_RESET;
			drive_d     = 1'b0;
			if (sleep_arm_q && !cs_prev_q) begin
				asleep_d = 1'b1;
			end
			sleep_arm_d = 1'b0;
		end else if (asleep_q) begin
			// wake on select; the latch is lost on return
			asleep_d = 1'b0;
			permit_d = 1'b0;
		end else begin
			if (rise) begin
				shin_d = byte_in;
				bit_d  = bit_q + 3'd1;
				sleep_arm_d = 1'b0;
			end
			if (byte_done) begin
				unique case (state_q)
					smsp_pkg::SMSP_OPCODE: begin
						if (byte_in == smsp_pkg::OP_SET_PERMIT)
							permit_d = 1'b1;
						else if (byte_in == smsp_pkg::OP_CLR_PERMIT)
							permit_d = 1'b0;
						if (byte_in == smsp_pkg::OP_STAT_READ) begin
							state_d = smsp_pkg::SMSP_STAT_RD;
							shout_d = stat_view;
						end else if (byte_in == smsp_pkg::OP_STAT_WRITE)
							state_d = smsp_pkg::SMSP_STAT_WR;
						else if (byte_in == smsp_pkg::OP_MEM_WRITE)
							state_d = smsp_pkg::SMSP_MEM_WR;
						else if (byte_in == smsp_pkg::OP_SLEEP) begin
							state_d     = smsp_pkg::SMSP_SLEEP_P;
							sleep_arm_d = 1'b1;
						end else
							state_d = smsp_pkg::SMSP_IGNORE;
					end
					smsp_pkg::SMSP_STAT_RD: begin
						// repeated reads while clocks continue
						shout_d = stat_view;
					end
					smsp_pkg::SMSP_STAT_WR: begin
						if (stat_ok)
							nv_d = (byte_in & smsp_pkg::STAT_WR_MASK) |
							       (nv_q & ~smsp_pkg::STAT_WR_MASK);
						state_d = smsp_pkg::SMSP_IGNORE;
					end
					smsp_pkg::SMSP_MEM_WR: state_d = smsp_pkg::SMSP_MEM_WR;
					smsp_pkg::SMSP_SLEEP_P: state_d = smsp_pkg::SMSP_IGNORE;
					smsp_pkg::SMSP_IGNORE: state_d = smsp_pkg::SMSP_IGNORE;
					default: state_d = smsp_pkg::SMSP_IGNORE;
				endcase
			end
			if (fall && state_q == smsp_pkg::SMSP_STAT_RD) begin
				// first bit after op-code comes from the freshly loaded byte
				so_d    = shout_q[3'd7 - bit_q];
				drive_d = 1'b1;
			end
		end
		if (!pause_s)
			drive_d = 1'b0;
		if (!clk_en) begin
			state_d = state_q; bit_d = bit_q; shin_d = shin_q; shout_d = shout_q;
			so_d = so_q; drive_d = drive_q; nv_d = nv_q; permit_d = permit_q;
			asleep_d = asleep_q; sleep_arm_d = sleep_arm_q; cs_prev_d = cs_prev_q;
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			state_q     <= smsp_pkg::SMSP_OPCODE;
			bit_q       <= smsp_pkg::BIT_CNT_RESET;
			shin_q      <= 8'h00;
			shout_q     <= 8'h00;
			so_q        <= 1'b0;
			drive_q     <= 1'b0;
			nv_q        <= smsp_pkg::STAT_RESET;
			permit_q    <= 1'b0;
			asleep_q    <= 1'b0;
			sleep_arm_q <= 1'b0;
			cs_prev_q   <= 1'b1;
		end else begin
			state_q     <= state_d;
			bit_q       <= bit_d;
			shin_q      <= shin_d;
			shout_q     <= shout_d;
			so_q        <= so_d;
			drive_q     <= drive_d;
			nv_q        <= nv_d;
			permit_q    <= permit_d;
			asleep_q    <= asleep_d;
			sleep_arm_q <= sleep_arm_d;
			cs_prev_q   <= cs_prev_d;
		end
	end

	// region guard decode; array write also needs the latch
	logic region_hit;
	always_comb begin
		unique case (nv_q[smsp_pkg::STAT_REGION_HI:smsp_pkg::STAT_REGION_LO])
			2'b00: region_hit = 1'b0;
			2'b01: region_hit = array_addr >= smsp_pkg::REGION_Q_BASE;
			2'b10: region_hit = array_addr >= smsp_pkg::REGION_H_BASE;
			2'b11: region_hit = 1'b1;
		endcase
	end

	assign array_wr_allow = permit_q & ~region_hit & (state_q == smsp_pkg::SMSP_MEM_WR);
	assign so     = so_q;
	assign so_oe  = drive_q & active;
	assign asleep = asleep_q;
	assign status = stat_view;
	// array read data is muxed by the array datapath; kept for port completeness
	logic unused_rd;
	assign unused_rd = ^array_rd_data;

	property p_so_off_deselect;
		@(posedge clock) disable iff (!nrst) cs_s |-> !so_oe;
	endproperty
	a_so_off_deselect: assert property (p_so_off_deselect) else $error("so driven while deselected");

	property p_so_off_pause;
		@(posedge clock) disable iff (!nrst) !pause_s |-> !so_oe;
	endproperty
	a_so_off_pause: assert property (p_so_off_pause) else $error("so driven in pause");

	property p_bit0_zero;
		@(posedge clock) disable iff (!nrst) status[0] == 1'b0;
	endproperty
	a_bit0_zero: assert property (p_bit0_zero) else $error("status bit 0 not zero");

	property p_permit_only_set_cmd;
		@(posedge clock) disable iff (!nrst) $rose(permit_q) |-> $past(byte_done) && $past(byte_in) == smsp_pkg::OP_SET_PERMIT && $past(state_q) == smsp_pkg::SMSP_OPCODE;
	endproperty
	a_permit_only_set_cmd: assert property (p_permit_only_set_cmd) else $error("latch set without set command");

	property p_permit_clear_cmd;
		@(posedge clock) disable iff (!nrst) (clk_en && !cs_s && !asleep_q && byte_done && state_q == smsp_pkg::SMSP_OPCODE && byte_in == smsp_pkg::OP_CLR_PERMIT) |=> !permit_q;
	endproperty
	a_permit_clear_cmd: assert property (p_permit_clear_cmd) else $error("clear command ignored");

	property p_guarded_status;
		@(posedge clock) disable iff (!nrst) (!stat_ok) |=> $stable(nv_q);
	endproperty
	a_guarded_status: assert property (p_guarded_status) else $error("status written while guarded");

	property p_stat_write_keeps_permit;
		@(posedge clock) disable iff (!nrst) (permit_q && state_q == smsp_pkg::SMSP_STAT_WR && byte_done && !cs_s) |=> permit_q;
	endproperty
	a_stat_write_keeps_permit: assert property (p_stat_write_keeps_permit) else $error("latch lost after write");

	property p_so_on_fall;
		@(posedge clock) disable iff (!nrst) $changed(so_q) |-> $past(fall);
	endproperty
	a_so_on_fall: assert property (p_so_on_fall) else $error("so moved off a falling edge");

	property p_full_region;
		@(posedge clock) disable iff (!nrst) nv_q[3:2] == 2'b11 |-> !array_wr_allow;
	endproperty
	a_full_region: assert property (p_full_region) else $error("write allowed in full guard");

	property p_no_region_open;
		@(posedge clock) disable iff (!nrst)
			(nv_q[3:2] == 2'b00 && permit_q && state_q == smsp_pkg::SMSP_MEM_WR) |-> array_wr_allow;
	endproperty
	a_no_region_open: assert property (p_no_region_open) else $error("open region refused");

	property p_sleep_quiet;
		@(posedge clock) disable iff (!nrst) asleep_q |-> !so_oe;
	endproperty
	a_sleep_quiet: assert property (p_sleep_quiet) else $error("so driven while asleep");

	// pause must not advance the bit count, else resume shifts misaligned
	property p_pause_keeps_count;
		@(posedge clock) disable iff (!nrst) (!pause_s && !cs_s) |=> $stable(bit_q);
	endproperty
	a_pause_keeps_count: assert property (p_pause_keeps_count) else $error("count moved in pause");

	property p_deselect_clears_count;
		@(posedge clock) disable iff (!nrst) (clk_en && cs_s) |=> bit_q == 3'd0;
	endproperty
	a_deselect_clears_count: assert property (p_deselect_clears_count) else $error("count kept");

	property p_stat_write_skips_latch;
		@(posedge clock) disable iff (!nrst)
			(state_q == smsp_pkg::SMSP_STAT_WR && byte_done) |=> permit_q == $past(permit_q);
	endproperty
	a_stat_write_skips_latch: assert property (p_stat_write_skips_latch) else $error("latch written");

	property p_no_edge_idle;
		@(posedge clock) disable iff (!nrst) !active |-> !rise && !fall;
	endproperty
	a_no_edge_idle: assert property (p_no_edge_idle) else $error("edge seen while idle");
endmodule

// ---- rtl/smsp_pkg.sv ----
// Purpose: shared constants for the serial memory status port
// Assumes: 8-bit protection status register, 18-bit array address
// Notes:   op-codes kept here so the decoder and the shifter agree
package smsp_pkg;
	localparam int          BYTE_BITS       = 8;
	localparam int          ADDR_BITS       = 18;
	// status register field positions
	localparam int          STAT_GUARD_EN   = 7;
	localparam int          STAT_SPARE_HI   = 6;
	localparam int          STAT_SPARE_LO   = 4;
	localparam int          STAT_REGION_HI  = 3;
	localparam int          STAT_REGION_LO  = 2;
	localparam int          STAT_PERMIT     = 1;
	localparam int          STAT_ZERO       = 0;
	localparam logic [7:0]  STAT_RESET      = 8'h00;
	localparam logic [7:0]  STAT_WR_MASK    = 8'hFC;
	// op-codes
	localparam logic [7:0]  OP_SET_PERMIT   = 8'h06;
	localparam logic [7:0]  OP_CLR_PERMIT   = 8'h04;
	localparam logic [7:0]  OP_STAT_READ    = 8'h05;
	localparam logic [7:0]  OP_STAT_WRITE   = 8'h01;
	localparam logic [7:0]  OP_MEM_WRITE    = 8'h02;
	localparam logic [7:0]  OP_SLEEP        = 8'hB9;
	// region guard lower bounds
	localparam logic [17:0] REGION_Q_BASE   = 18'h3_0000;
	localparam logic [17:0] REGION_H_BASE   = 18'h2_0000;
	localparam logic [2:0]  BIT_CNT_RESET   = 3'h0;

	typedef enum logic [2:0] {
		SMSP_OPCODE = 3'b000,
		SMSP_STAT_RD = 3'b001,
		SMSP_STAT_WR = 3'b010,
		SMSP_MEM_WR  = 3'b011,
		SMSP_SLEEP_P = 3'b100,
		SMSP_IGNORE  = 3'b101
	} smsp_state_t;
endpackage

// ---- rtl/smsp_sync.sv ----
// Purpose: two-stage synchroniser for asynchronous pins
// Assumes: inputs arrive from outside the clock domain
// Notes:   first stage read only by the second
module smsp_sync #(
	parameter int        W   = 1,
	parameter logic [W-1:0] RST = '0
) (
	// clock and reset
	input  wire logic         clock,
	input  wire logic         nrst,
	input  wire logic         en,
	// data
	input  wire logic [W-1:0] din,
	output logic      [W-1:0] dout
);
	logic [W-1:0] meta_q;
	logic [W-1:0] meta_d;
	logic [W-1:0] sync_q;
	logic [W-1:0] sync_d;

	always_comb begin
		meta_d = en ? din : meta_q;
		sync_d = en ? meta_q : sync_q;
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			meta_q <= RST;
			sync_q <= RST;
		end else begin
			meta_q <= meta_d;
			sync_q <= sync_d;
		end
	end

	assign dout = sync_q;
endmodule

// ---- rtl/smsp_edge.sv ----
// Purpose: serial clock edge finder gated by select and pause
// Assumes: sck already synchronised
// Notes:   edges during pause or deselect are swallowed
module smsp_edge (
	// clock and reset
	input  wire logic clock,
	input  wire logic nrst,
	input  wire logic en,
	// link levels
	input  wire logic sck,
	input  wire logic active,
	// edges
	output logic      rise,
	output logic      fall
);
	logic prev_q;
	logic prev_d;

	always_comb begin
		prev_d = en ? sck : prev_q;
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst)
			prev_q <= 1'b0;
		else
			prev_q <= prev_d;
	end

	// tracking continues in pause so resume at same level gives no false edge
	assign rise = en & active & sck & ~prev_q;
	assign fall = en & active & ~sck & prev_q;
endmodule

// ---- sim/smsp_host_model.sv ----
// Purpose: host spi master model for the serial status port
// Assumes: sck half period 80 ns, ten system clocks
// Notes:   pins change 1 ns after a clock edge; modes 0 and 3
module smsp_host_model (
	// system clock
	input  wire logic clock,
	// serial pins
	input  wire logic so,
	output logic      cs_n,
	output logic      sck,
	output logic      si,
	output logic      pause_n
);
	timeunit 1ns;
	timeprecision 100ps;
	logic cpol;
	initial begin
		cpol = 1'b0;
		cs_n = 1'b1;
		sck = 1'b0;
		si = 1'b0;
		pause_n = 1'b1;
	end
	task automatic step(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask
	// idle level of sck only moves while deselected
	task automatic mode(input logic m);
		cpol = m;
		sck = m;
		step(10);
	endtask
	task automatic sel();
		cs_n = 1'b0;
		step(10);
	endtask
	task automatic desel();
		cs_n = 1'b1;
		si = ~si; // no stale level once released
		step(10);
	endtask
	task automatic xbyte(input logic [7:0] tx, output logic [7:0] rx);
		for (int i = 7; i >= 0; i--) begin
			sck = 1'b0;
			si = tx[i];
			step(10);
			sck = 1'b1;
			rx[i] = so;
			step(10);
		end
		sck = cpol;
		if (!cpol) step(10);
	endtask
	// sck stays put, so pause ends at the level it began
	task automatic hold(input logic v);
		pause_n = v;
		step(10);
	endtask
endmodule

// ---- sim/smsp_port_bench.sv ----
// Purpose: self-checking bench for the serial status port
// Assumes: link half period 80 ns against 8 ns system clock
// Notes:   array read data tied; array side only grants writes
module smsp_port_bench;
	timeunit 1ns;
	timeprecision 100ps;
	logic        clock, nrst, write_guard_n, so, so_oe, array_wr_allow, asleep;
	logic        cs_n, sck, si, pause_n, clk_en;
	logic [7:0]  rd_byte;
	logic [17:0] array_addr;
	logic [7:0]  status, rx;
	int          n_errors = 0, n_compared = 0;

	smsp_port dut (.clock(clock), .nrst(nrst), .clk_en(clk_en), .cs_n(cs_n), .sck(sck),
		.si(si), .pause_n(pause_n), .write_guard_n(write_guard_n), .so(so),
		.so_oe(so_oe), .array_rd_data(rd_byte), .array_addr(array_addr),
		.array_wr_allow(array_wr_allow), .asleep(asleep), .status(status));
	smsp_host_model host (.clock(clock), .so(so), .cs_n(cs_n), .sck(sck), .si(si),
		.pause_n(pause_n));

	initial begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end
	task automatic give_verdict();
		$display("compared %0d errors %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		n_compared++;
		if (g !== e) begin
			$display("ERROR %s expected %h seen %h", n, e, g);
			n_errors++;
		end
	endtask
	task automatic cmd(input logic [7:0] op);
		host.sel();
		host.xbyte(op, rx);
		host.desel();
	endtask
	task automatic wr(input logic [7:0] d);
		host.sel();
		host.xbyte(smsp_pkg::OP_STAT_WRITE, rx);
		host.xbyte(d, rx);
		host.desel();
	endtask
	task automatic t_start();
		chk("status", 8'h00, status);
		chk("oe", 8'h00, {7'h0, so_oe});
		host.xbyte(smsp_pkg::OP_SET_PERMIT, rx);
		chk("ignored", 8'h00, status);
		wr(8'hFF);
		chk("locked", 8'h00, status);
	endtask
	task automatic t_write();
		cmd(smsp_pkg::OP_SET_PERMIT);
		chk("permit", 8'h02, status);
		wr(8'hFF);
		chk("all", 8'hFE, status);
		wr(8'h51);
		chk("low_bits", 8'h52, status);
	endtask
	task automatic t_read();
		host.mode(1'b1);
		host.sel();
		host.xbyte(smsp_pkg::OP_STAT_READ, rx);
		host.xbyte(8'h00, rx);
		chk("rd_m3", 8'h52, rx);
		chk("oe", 8'h01, {7'h0, so_oe});
		host.hold(1'b0);
		chk("oe_hold", 8'h00, {7'h0, so_oe});
		host.hold(1'b1);
		host.xbyte(8'h00, rx);
		chk("rd_again", 8'h52, rx);
		host.desel();
		chk("oe_off", 8'h00, {7'h0, so_oe});
		host.mode(1'b0);
		host.sel();
		host.xbyte(smsp_pkg::OP_STAT_READ, rx);
		host.xbyte(8'h00, rx);
		host.desel();
		chk("rd_m0", 8'h52, rx);
	endtask
	task automatic t_guard();
		wr(8'hD2);
		chk("guard_en", 8'hD2, status);
		write_guard_n = 1'b0;
		wr(8'h00);
		chk("guarded", 8'hD2, status);
		write_guard_n = 1'b1;
		wr(8'h04);
		chk("unguarded", 8'h06, status);
	endtask
	// one write frame per region code, three probe addresses each
	task automatic t_region();
		logic [17:0] a[3] = '{18'h1_FFFF, 18'h2_FFFF, 18'h3_0000};
		logic        e;
		for (int c = 0; c < 4; c++) begin
			wr({4'h0, c[1:0], 2'b00});
			host.sel();
			host.xbyte(smsp_pkg::OP_MEM_WRITE, rx);
			for (int k = 0; k < 3; k++) begin
				array_addr = a[k];
				host.step(4);
				e = !(c == 3 || (c == 2 && k > 0) || (c == 1 && k == 2));
				chk("wr_allow", {7'h0, e}, {7'h0, array_wr_allow});
			end
			host.desel();
		end
	endtask
	task automatic t_sleep();
		cmd(smsp_pkg::OP_CLR_PERMIT);
		chk("cleared", 8'h0C, status);
		cmd(smsp_pkg::OP_SET_PERMIT);
		cmd(smsp_pkg::OP_SLEEP);
		chk("asleep", 8'h01, {7'h0, asleep});
		host.sel();
		chk("awake", 8'h00, {7'h0, asleep});
		chk("woken", 8'h0C, status);
		host.desel();
		clk_en = 1'b0;
		cmd(smsp_pkg::OP_SET_PERMIT);
		chk("frozen", 8'h0C, status);
		clk_en = 1'b1;
		host.step(4);
	endtask
	initial begin
		nrst = 1'b0;
		write_guard_n = 1'b1;
		clk_en = 1'b1;
		rd_byte = 8'hA5;
		array_addr = 18'h0_0000;
		repeat (6) @(posedge clock);
		#1 nrst = 1'b1;
		host.step(4);
		t_start();
		t_write();
		t_read();
		t_guard();
		t_region();
		t_sleep();
		give_verdict();
	end
	// 22 frames of under 5 us each
	initial begin
		#400000;
		n_errors++;
		give_verdict();
	end
endmodule
